// [inc/clkgen_consts.svh]
`ifndef CLKGEN_CONSTS_SVH
`define CLKGEN_CONSTS_SVH
`define OFS_CONTROL      12'h000
`define OFS_BANDWIDTH    12'h004
`define OFS_VCO_RANGE    12'h008
`define OFS_CONFIG       12'h00c
`define OFS_MONITOR      12'h010
`define CTL_INT_EN_BIT   7
`define CTL_FLAG_BIT     6
`define CTL_PLL_ON_BIT   5
`define CTL_BCS_BIT      4
`define BW_AUTO_BIT      7
`define BW_LOCK_BIT      6
`define BW_ACQ_BIT       5
`define CFG_OSC_STOP_BIT 0
`define CFG_BCE_BIT      1
`define RST_PRESCALE     2'h0
`define RST_RANGE        2'h0
`define LOCK_TICKS       8'h40
`define VCO_BASE_PERIOD  4'h8
`define BAUD_DIV         8'hff
`endif

// [inc/clkgen_pkg.sv]
package clkgen_pkg;
  typedef enum logic [0:0] {SEL_RUN = 1'b0, SEL_WAIT = 1'b1} sel_state_type;
  typedef enum logic [2:0] {
    MON_NONE    = 3'b000,
    MON_TST_BYP = 3'b001,
    MON_TST_DV4 = 3'b010,
    MON_SUPPLY  = 3'b011,
    MON_PLL     = 3'b100
  } mon_mode_type;
endpackage : clkgen_pkg

// [hdl/pll_clock_generator.sv]
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "clkgen_consts.svh"
module pll_clock_generator
  import clkgen_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        stopMode,
  input  wire logic        breakActive,
  input  wire logic        oscInputPin,
  input  wire logic        monitorEntry,
  input  wire logic        testHighVoltage,
  input  wire logic        divisorStrapPin,
  input  wire logic        irqPinLow,
  input  wire logic        resetVectorErased,
  output logic             oscClockTick,
  output logic             vcoClockTick,
  output logic             dividedVcoTick,
  output logic             baseClockTick,
  output logic             busClockTick,
  output logic             baudTick,
  output logic             clockgenInterrupt
);
  // Register state
  logic          intEn_q;
  logic          flag_q;
  logic          pll_power_on_q;
  logic          bcs_q;
  logic [1:0]    prescale_q;
  logic          autoBw_q;
  logic          acqBit_q;
  logic [1:0]    range_q;
  logic          oscRunInStop_q;
  logic          breakClearEn_q;
  mon_mode_type  monMode_q;
  logic [31:0]   prdata_q;
  // Clock path state
  logic          oscPinPrev_q;
  logic [3:0]    vcoCnt_q;
  logic [2:0]    preCnt_q;
  logic [7:0]    lockCnt_q;
  logic          locked_q;
  logic          lockPrev_q;
  logic          stopPrev_q;
  logic          selVco_q;
  sel_state_type selState_q;
  logic          baseDiv_q;
  logic          busDiv_q;
  logic [7:0]    baudCnt_q;
  logic          oscTick;
  logic          vcoTick;
  logic          pclkTick;
  logic          baseTick;
  logic          busTick;
  logic          allQuiet;
  logic          pllRun;
  logic          bcsEff;
  logic          monPll;
  logic          acquiring;
  logic          acqRead;
  logic          lockRead;
  logic          apbWrite;
  logic          apbRead;
  logic          ctlRead;
  logic          wantVco;
  logic          srcTick;
  logic          newTick;
  logic [3:0]    vcoPeriod;
  logic [31:0]   readMux;
  logic          mapped;
  function automatic logic [2:0] prescale_mask(input logic [1:0] code);
    prescale_mask = 3'((4'h1 << code) - 4'h1);
  endfunction : prescale_mask
  // Bus slave, zero wait in access phase
  assign apbWrite = psel & penable & pwrite;
  assign apbRead  = psel & penable & ~pwrite;
  assign ctlRead  = apbRead & (paddr == `OFS_CONTROL);
  assign pready   = 1'b1;
  assign prdata   = prdata_q;
  assign mapped   = (paddr == `OFS_CONTROL) | (paddr == `OFS_BANDWIDTH) |
                    (paddr == `OFS_VCO_RANGE) | (paddr == `OFS_CONFIG) |
                    (paddr == `OFS_MONITOR);
  assign pslverr  = psel & penable & ~mapped;
  // Mode and lock derivations
  assign monPll    = (monMode_q == MON_PLL);
  assign allQuiet  = stopMode & ~oscRunInStop_q;
  assign pllRun    = ((pll_power_on_q & (monMode_q == MON_NONE)) | monPll) & ~stopMode;
  assign acquiring = autoBw_q ? ~locked_q : ~acqBit_q;
  assign acqRead   = ~acquiring;
  assign lockRead  = locked_q & pllRun;
  assign bcsEff    = (bcs_q | (monPll & lockRead)) & pllRun;
  always_comb
  begin
    readMux = 32'h0000_0000;
    case (paddr)
      `OFS_CONTROL:
      begin
        readMux[`CTL_INT_EN_BIT] = intEn_q;
        readMux[`CTL_FLAG_BIT]   = flag_q;
        readMux[`CTL_PLL_ON_BIT] = pll_power_on_q;
        readMux[`CTL_BCS_BIT]    = bcs_q;
        readMux[1:0]             = prescale_q;
      end
      `OFS_BANDWIDTH:
      begin
        readMux[`BW_AUTO_BIT] = autoBw_q;
        readMux[`BW_LOCK_BIT] = lockRead;
        readMux[`BW_ACQ_BIT]  = acqRead;
      end
      `OFS_VCO_RANGE: readMux[1:0] = range_q;
      `OFS_CONFIG:
      begin
        readMux[`CFG_OSC_STOP_BIT] = oscRunInStop_q;
        readMux[`CFG_BCE_BIT]      = breakClearEn_q;
      end
      `OFS_MONITOR: readMux[2:0] = monMode_q;
      default: readMux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge sys_clk)
    if (rst)
      prdata_q <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
      prdata_q <= readMux;
  // Software control registers
  always_ff @(posedge sys_clk)
    if (rst)
    begin
      intEn_q        <= 1'b0;
      pll_power_on_q        <= 1'b0;
      prescale_q     <= `RST_PRESCALE;
      autoBw_q       <= 1'b0;
      acqBit_q       <= 1'b0;
      range_q        <= `RST_RANGE;
      oscRunInStop_q <= 1'b0;
      breakClearEn_q <= 1'b0;
    end
    else if (apbWrite)
      case (paddr)
        `OFS_CONTROL:
        begin
          intEn_q    <= pwdata[`CTL_INT_EN_BIT];
          pll_power_on_q    <= pwdata[`CTL_PLL_ON_BIT];
          prescale_q <= pwdata[1:0];
        end
        `OFS_BANDWIDTH:
        begin
          autoBw_q <= pwdata[`BW_AUTO_BIT];
          acqBit_q <= pwdata[`BW_ACQ_BIT];
        end
        `OFS_VCO_RANGE:
          if (!pll_power_on_q)
            range_q <= pwdata[1:0];
        `OFS_CONFIG:
        begin
          oscRunInStop_q <= pwdata[`CFG_OSC_STOP_BIT];
          breakClearEn_q <= pwdata[`CFG_BCE_BIT];
        end
        default: ;
      endcase
  // Base source select, forced clear on stop entry
  always_ff @(posedge sys_clk)
    if (rst)
      bcs_q <= 1'b0;
    else if (stopMode & ~stopPrev_q)
      bcs_q <= 1'b0;
    else if (apbWrite & (paddr == `OFS_CONTROL))
      bcs_q <= pwdata[`CTL_BCS_BIT];
  // Event flag: set wins, break protects it
  always_ff @(posedge sys_clk)
    if (rst)
      flag_q <= 1'b0;
    else if (lockRead != lockPrev_q)
      flag_q <= 1'b1;
    else if (ctlRead & (~breakActive | breakClearEn_q))
      flag_q <= 1'b0;
  // Monitor entry strap capture
  always_ff @(posedge sys_clk)
    if (rst)
      monMode_q <= MON_NONE;
    else if (monitorEntry)
    begin
      if (testHighVoltage)
        monMode_q <= divisorStrapPin ? MON_TST_DV4 : MON_TST_BYP;
      else if (!resetVectorErased)
        monMode_q <= MON_NONE;
      else
        monMode_q <= irqPinLow ? MON_PLL : MON_SUPPLY;
    end
  // Oscillator edge and VCO model
  assign oscTick   = oscInputPin & ~oscPinPrev_q & ~allQuiet;
  assign vcoPeriod = `VCO_BASE_PERIOD >> range_q;
  assign vcoTick   = pllRun & (vcoCnt_q == 4'h0);
  assign pclkTick  = vcoTick & ((preCnt_q & prescale_mask(prescale_q)) == 3'h0);
  always_ff @(posedge sys_clk)
    if (rst)
    begin
      oscPinPrev_q <= 1'b0;
      stopPrev_q   <= 1'b0;
      lockPrev_q   <= 1'b0;
    end
    else
    begin
      oscPinPrev_q <= oscInputPin;
      stopPrev_q   <= stopMode;
      lockPrev_q   <= lockRead;
    end

  always_ff @(posedge sys_clk)
    if (rst | ~pllRun)
    begin
      vcoCnt_q <= 4'h0;
      preCnt_q <= 3'h0;
    end
    else
    begin
      vcoCnt_q <= (vcoCnt_q == 4'h0) ? vcoPeriod - 4'h1 : vcoCnt_q - 4'h1;
      if (vcoTick)
        preCnt_q <= preCnt_q + 3'h1;
    end
  // Lock detector
  always_ff @(posedge sys_clk)
    if (rst | ~pllRun)
    begin
      lockCnt_q <= 8'h00;
      locked_q  <= 1'b0;
    end
    else if (vcoTick & ~locked_q)
    begin
      lockCnt_q <= lockCnt_q + 8'h01;
      locked_q  <= (lockCnt_q == `LOCK_TICKS - 8'h01);
    end
  // Glitch-free base source switch
  assign wantVco = bcsEff & (monMode_q != MON_TST_BYP);
  assign srcTick = selVco_q ? pclkTick : oscTick;
  assign newTick = wantVco ? pclkTick : oscTick;

  always_ff @(posedge sys_clk)
    if (rst)
    begin
      selState_q <= SEL_RUN;
      selVco_q   <= 1'b0;
      baseDiv_q  <= 1'b0;
    end
    else
      case (selState_q)
        SEL_RUN:
          if (wantVco != selVco_q && !baseDiv_q)
            selState_q <= SEL_WAIT;
          else if (srcTick)
            baseDiv_q <= ~baseDiv_q;
        SEL_WAIT:
          if (newTick)
          begin
            selVco_q   <= wantVco;
            baseDiv_q  <= 1'b1;
            selState_q <= SEL_RUN;
          end
        default: selState_q <= SEL_RUN;
      endcase
  assign baseTick = (monMode_q == MON_TST_BYP) ? oscTick :
                    (selState_q == SEL_RUN) & srcTick & baseDiv_q;
  assign busTick  = baseTick & busDiv_q;

  always_ff @(posedge sys_clk)
    if (rst)
    begin
      busDiv_q  <= 1'b0;
      baudCnt_q <= 8'h00;
    end
    else if (baseTick)
    begin
      busDiv_q <= ~busDiv_q;
      if (busTick)
        baudCnt_q <= baudCnt_q + 8'h01;
    end
  // Registered outputs, all held low in quiet stop
  always_ff @(posedge sys_clk)
    if (rst | allQuiet)
    begin
      oscClockTick      <= 1'b0;
      vcoClockTick      <= 1'b0;
      dividedVcoTick    <= 1'b0;
      baseClockTick     <= 1'b0;
      busClockTick      <= 1'b0;
      baudTick          <= 1'b0;
      clockgenInterrupt <= 1'b0;
    end
    else
    begin
      oscClockTick      <= oscTick;
      vcoClockTick      <= vcoTick;
      dividedVcoTick    <= pclkTick;
      baseClockTick     <= baseTick;
      busClockTick      <= busTick;
      baudTick          <= busTick & (baudCnt_q == `BAUD_DIV);
      clockgenInterrupt <= flag_q & intEn_q;
    end
  // Checks
  a_acq_readback: assert property (@(posedge sys_clk) disable iff (rst)
    (psel && !penable && !pwrite && paddr == `OFS_BANDWIDTH) |=>
    prdata_q[`BW_ACQ_BIT] == !$past(acquiring)) else $error("acquire bit wrong on read");
  a_auto_tracks: assert property (@(posedge sys_clk) disable iff (rst)
    (autoBw_q && locked_q) |-> !acquiring) else $error("auto mode not tracking");
  a_lock_safe: assert property (@(posedge sys_clk) disable iff (rst)
    lockRead |-> (lockCnt_q == `LOCK_TICKS) && pllRun) else $error("lock too early");
  a_range_frozen: assert property (@(posedge sys_clk) disable iff (rst)
    (apbWrite && paddr == `OFS_VCO_RANGE && pll_power_on_q) |=> $stable(range_q))
    else $error("range changed while PLL on");
  a_stop_silent: assert property (@(posedge sys_clk) disable iff (rst)
    (stopMode && !oscRunInStop_q) |=> !oscClockTick && !baseClockTick &&
    !vcoClockTick && !clockgenInterrupt) else $error("output active in stop");
  a_stop_bcs: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(stopMode) |=> !bcs_q) else $error("source select kept in stop");
  a_break_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (ctlRead && breakActive && !breakClearEn_q && flag_q) |=> flag_q)
    else $error("flag lost in break");
  a_strap_ignore: assert property (@(posedge sys_clk) disable iff (rst)
    (monitorEntry && !testHighVoltage) |=> monMode_q != MON_TST_BYP &&
    monMode_q != MON_TST_DV4) else $error("strap used without test voltage");
  a_bypass_equal: assert property (@(posedge sys_clk) disable iff (rst)
    (monMode_q == MON_TST_BYP && !allQuiet) |-> baseTick == oscTick)
    else $error("bypass not equal to oscillator");
  a_switch_gap: assert property (@(posedge sys_clk) disable iff (rst)
    (selState_q == SEL_WAIT && monMode_q != MON_TST_BYP) |-> !baseTick)
    else $error("base pulse during switch");

endmodule : pll_clock_generator

// [test/osc_source.sv]
`timescale 1ns/100ps
module osc_source
(
  input  wire logic sys_clk,
  input  wire logic rst,
  output logic      oscLevel
);
  logic [1:0] phaseQ;

  // Crystal at a fixed rate, one rising edge per four cycles
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      phaseQ <= 2'h0;
    end
    else
    begin
      phaseQ <= phaseQ + 2'h1;
    end
  end

  assign oscLevel = phaseQ[1];
endmodule : osc_source

// [test/test_pll_clock_generator.sv]
`timescale 1ns/100ps
`include "clkgen_consts.svh"
module test_pll_clock_generator
  import clkgen_pkg::*;
;
  logic        sys_clk, rst, psel, penable, pwrite, stopMode, breakActive, monitorEntry;
  logic        testHighVoltage, divisorStrapPin, irqPinLow, resetVectorErased, err;
  logic        pready, pslverr, oscInputPin, clockgenInterrupt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  wire  [5:0]  ticks;
  int          badCount, checked, i, n;
  logic [3:0]  mIn [5] = '{4'h8, 4'hc, 4'h5, 4'h4, 4'h3};
  int          mMode [5] = '{1, 2, 3, 0, 4};
  int          mDiv [5] = '{2, 4, 4, 4, 0};

  osc_source osc_u (.sys_clk(sys_clk), .rst(rst), .oscLevel(oscInputPin));

  pll_clock_generator dut_u (
    .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stopMode(stopMode), .breakActive(breakActive),
    .oscInputPin(oscInputPin), .monitorEntry(monitorEntry),
    .testHighVoltage(testHighVoltage), .divisorStrapPin(divisorStrapPin),
    .irqPinLow(irqPinLow), .resetVectorErased(resetVectorErased),
    .oscClockTick(ticks[0]), .vcoClockTick(ticks[1]), .dividedVcoTick(ticks[2]),
    .baseClockTick(ticks[3]), .busClockTick(ticks[4]), .baudTick(ticks[5]),
    .clockgenInterrupt(clockgenInterrupt));

  task report_and_stop;
    $display("checked %0d bad %0d", checked, badCount);
    if (badCount == 0 && checked > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task check_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      badCount++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check_word

  task check_bit(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask : check_bit

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'h1 && k < 50);
    if (k >= 50)
    begin
      check_word(32'h0, 32'h1);
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // Ticks of a in the span between two later ticks of b
  task ratio(input int a, input int b, input int exp);
    int k, s;
    n = 0;
    s = 0;
    for (k = 0; k < 20000 && s < 3; k++)
    begin
      @(posedge sys_clk);
      if (s == 2 && ticks[a] === 1'h1) n++;
      if (ticks[b] === 1'h1) s++;
    end
    if (s < 3)
    begin
      check_word(32'h0, 32'h1);
      report_and_stop();
    end
    check_word(n, exp);
  endtask : ratio

  task count_ticks(input int idx);
    n = 0;
    repeat (3) @(posedge sys_clk);
    repeat (60)
    begin
      @(posedge sys_clk);
      if (ticks[idx] === 1'h1) n++;
    end
  endtask : count_ticks

  task t_regs;
    for (i = 0; i < 5; i++)
    begin
      apb(1'h0, 12'(4 * i), 32'h0);
      check_word(rd, 32'h0);
    end
    apb(1'h0, 12'h014, 32'h0);
    check_bit(err, 1'h1);
    $display("test regs done");
  endtask : t_regs

  task t_range;
    apb(1'h1, `OFS_VCO_RANGE, 32'h2);
    apb(1'h0, `OFS_VCO_RANGE, 32'h0);
    check_word(rd, 32'h2);
    apb(1'h1, `OFS_CONTROL, 32'ha0);
    apb(1'h1, `OFS_VCO_RANGE, 32'h1);
    apb(1'h0, `OFS_VCO_RANGE, 32'h0);
    check_word(rd, 32'h2);
    $display("test range done");
  endtask : t_range

  task t_lock;
    apb(1'h1, `OFS_BANDWIDTH, 32'h80);
    apb(1'h0, `OFS_BANDWIDTH, 32'h0);
    check_bit(rd[`BW_ACQ_BIT], 1'h0);
    for (i = 0; i < 100 && rd[`BW_LOCK_BIT] !== 1'h1; i++) apb(1'h0, `OFS_BANDWIDTH, 32'h0);
    check_bit(rd[`BW_LOCK_BIT], 1'h1);
    check_bit(rd[`BW_ACQ_BIT], 1'h1);
    repeat (2) @(posedge sys_clk);
    check_bit(clockgenInterrupt, 1'h1);
    $display("test lock done");
  endtask : t_lock

  task t_break;
    breakActive <= 1'h1;
    apb(1'h0, `OFS_CONTROL, 32'h0);
    apb(1'h0, `OFS_CONTROL, 32'h0);
    check_bit(rd[`CTL_FLAG_BIT], 1'h1);
    apb(1'h1, `OFS_CONFIG, 32'h2);
    apb(1'h0, `OFS_CONTROL, 32'h0);
    breakActive <= 1'h0;
    apb(1'h0, `OFS_CONTROL, 32'h0);
    check_bit(rd[`CTL_FLAG_BIT], 1'h0);
    $display("test break done");
  endtask : t_break

  task t_prescale;
    for (i = 0; i < 4; i++)
    begin
      apb(1'h1, `OFS_CONTROL, 32'h20 | i);
      ratio(1, 2, 1 << i);
    end
    $display("test prescale done");
  endtask : t_prescale

  task t_stop;
    apb(1'h1, `OFS_CONTROL, 32'h30);
    ratio(2, 3, 2);
    stopMode <= 1'h1;
    for (i = 0; i < 4; i++)
    begin
      count_ticks(i);
      check_word(n, 32'h0);
    end
    stopMode <= 1'h0;
    apb(1'h0, `OFS_CONTROL, 32'h0);
    check_bit(rd[`CTL_BCS_BIT], 1'h0);
    apb(1'h1, `OFS_CONFIG, 32'h1);
    stopMode <= 1'h1;
    count_ticks(1);
    check_word(n, 32'h0);
    count_ticks(0);
    check_bit(n > 0, 1'h1);
    stopMode <= 1'h0;
    ratio(0, 3, 2);
    $display("test stop done");
  endtask : t_stop

  task t_monitor;
    for (i = 0; i < 5; i++)
    begin
      @(posedge sys_clk);
      {testHighVoltage, divisorStrapPin, irqPinLow, resetVectorErased} <= mIn[i];
      monitorEntry <= 1'h1;
      @(posedge sys_clk);
      monitorEntry <= 1'h0;
      apb(1'h0, `OFS_MONITOR, 32'h0);
      check_word(rd, mMode[i]);
      if (mDiv[i] > 0) ratio(0, 4, mDiv[i]);
      if (i == 0) ratio(0, 3, 1);
      if (i == 0) ratio(4, 5, 256);
    end
    count_ticks(1);
    check_bit(n > 0, 1'h1);
    $display("test monitor done");
  endtask : t_monitor

  initial
  begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial
  begin
    {rst, psel, penable, pwrite, stopMode, breakActive, monitorEntry} = 7'h40;
    {testHighVoltage, divisorStrapPin, irqPinLow, resetVectorErased} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    badCount = 0;
    checked = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'h0;
    t_regs();
    t_range();
    t_lock();
    t_break();
    t_prescale();
    t_stop();
    t_monitor();
    report_and_stop();
  end
endmodule : test_pll_clock_generator
